// [rtl/lookup_store.sv]
// Purpose: Nonvolatile lookup table storage, 72 entries of 8 bits
// Assumes: Erase input stands in for factory programming
// Notes: Two read ports, one for the host and one for compensation
`timescale 1ns/100ps
`include "wiper_ctrl_cfg.svh"
module lookup_store (
  // Clock
  input wire logic i_clock,
  // Factory erase
  input wire logic i_nv_erase,
  // Host write
  input wire logic i_wr,
  input wire logic [6:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Reads
  input wire logic [6:0] i_host_idx,
  input wire logic [6:0] i_comp_idx,
  output logic [7:0] o_host_data,
  output logic [7:0] o_comp_data
);
  logic [7:0] mem_q [`LOOKUP_DEPTH];

  // No power-on reset: contents survive it like the real cells
  always_ff @(posedge i_clock) begin
    for (int i = 0; i < `LOOKUP_DEPTH; i++) begin
      if (i_nv_erase) begin
        mem_q[i] <= `RST_LOOKUP_ENTRY;
      end else if (i_wr && (i_waddr == 7'(i))) begin
        mem_q[i] <= i_wdata;
      end
    end
  end

  // Indexes past the last slot read the last slot
  assign o_host_data = mem_q[(i_host_idx > `LOOKUP_LAST_INDEX) ? `LOOKUP_LAST_INDEX : i_host_idx];
  assign o_comp_data = mem_q[(i_comp_idx > `LOOKUP_LAST_INDEX) ? `LOOKUP_LAST_INDEX : i_comp_idx];
endmodule

// [rtl/temp_compensated_wiper_control.sv]
// Purpose: Register bank that sets a temperature compensated wiper position
// Assumes: Serial engine and converter run on i_clock and give one-cycle pulses
// Notes: Nonvolatile copies are flip-flops without power-on reset
//
// What this block does
// - update-select 0 loads the stored initial value into the wiper at power-up
// - update-select 0 stops refreshing temperature and supply results
// - update-select 1 lets host writes or lookup logic drive the wiper
// - lookup index picks one of 72 slots whose output sets the wiper
// - adder-select only matters while update-select is 1
// - adder-select 0 loads lookup output directly, no addition
// - adder-select 1 loads lookup output plus initial value
// - mode control recalled from nonvolatile copy at power-up; inhibit steers later writes
// - lookup index always readable, host writes taken only with index-override set
// - wiper value always readable, host writes taken only with manual-wiper and update-select both set
// - wiper value is an unsigned 7-bit quantity
// - update-select 1 refreshes wiper each frame, else wiper keeps address 00h value
// - manual-wiper 0 in lookup modes lets sum or lookup output set wiper
// - manual-wiper 1 stops automatic wiper loading, host writes set it
// - index-override 0 recomputes lookup index after every conversion
// - index-override 1 freezes lookup index at the host value
// - temperature result is 8-bit two's complement, refreshed each frame
// - update-select 0 means no converter writes to temperature result
// - update-select 0 disables converter; result registers stay readable
// - nonvolatile-write-inhibit bit is volatile and resets to 0
// - inhibit 1 makes address 00h writes touch only the volatile wiper
// - lookup entries unsigned 8-bit without adder, signed 7-bit with adder
`timescale 1ns/100ps
`include "wiper_ctrl_cfg.svh"
module temp_compensated_wiper_control (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Factory programming of nonvolatile copies
  input wire logic i_nv_erase,
  // Register access from the serial engine
  input wire wiper_ctrl_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Converter
  input wire wiper_ctrl_pkg::conv_sample_t i_conv,
  output logic o_conv_enable,
  // Wiper position
  output logic [6:0] o_wiper
);
  import wiper_ctrl_pkg::*;

  boot_state_t state_q;
  logic [7:0] mode_q;
  logic [7:0] nv_mode_q;
  logic [7:0] init_q;
  logic inhibit_q;
  logic ovr_index_q;
  logic ovr_manual_q;
  logic [7:0] index_q;
  logic [6:0] wiper_q;
  logic [7:0] temp_q;
  logic [7:0] volt_q;
  logic load_q;
  logic [7:0] rdata_q;
  logic rvalid_q;

  logic run;
  logic upd;
  logic adder;
  logic w00;
  logic w03;
  logic w08;
  logic w09;
  logic w0a;
  logic w02;
  logic lut_hit;
  logic [7:0] lut_host;
  logic [7:0] lut_comp;
  logic [6:0] auto_wiper;

  // Register decode, used for the single-address write strobe compares
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Clamp a signed sum into the 7-bit wiper range
  function automatic logic [6:0] sat7(input logic signed [9:0] v);
    if (v < 0) begin
      sat7 = 7'h00;
    end else if (v > $signed({3'b000, `WIPER_MAX})) begin
      sat7 = `WIPER_MAX;
    end else begin
      sat7 = v[6:0];
    end
  endfunction

  // Two-degree slots from -41 upward, clamped to the table ends
  function automatic logic [7:0] temp_to_index(input logic [7:0] t);
    logic signed [9:0] v;
    v = $signed({{2{t[7]}}, t}) + $signed(`TEMP_INDEX_BIAS);
    if (v < 0) begin
      temp_to_index = 8'h00;
    end else if ((v >>> 1) > $signed({3'b000, `LOOKUP_LAST_INDEX})) begin
      temp_to_index = {1'b0, `LOOKUP_LAST_INDEX};
    end else begin
      temp_to_index = 8'(v >>> 1);
    end
  endfunction

  assign run = (state_q == ST_RUN);
  assign upd = mode_q[`BIT_UPDATE_SELECT];
  assign adder = mode_q[`BIT_ADDER_SELECT] && upd;
  assign w00 = run && i_req.wr && hit(i_req.addr, `OFF_INITIAL_VALUE);
  assign w02 = run && i_req.wr && hit(i_req.addr, `OFF_SHADOW_CONTROL);
  assign w03 = run && i_req.wr && hit(i_req.addr, `OFF_WIPER_MODE_CONTROL);
  assign w08 = run && i_req.wr && hit(i_req.addr, `OFF_LOOKUP_INDEX);
  assign w09 = run && i_req.wr && hit(i_req.addr, `OFF_WIPER_VALUE);
  assign w0a = run && i_req.wr && hit(i_req.addr, `OFF_WIPER_OVERRIDE_CONTROL);
  assign lut_hit = (i_req.addr >= `OFF_LOOKUP_FIRST) && (i_req.addr <= `OFF_LOOKUP_LAST);

  lookup_store u_lookup (
    .i_clock(i_clock),
    .i_nv_erase(i_nv_erase),
    .i_wr(run && i_req.wr && lut_hit),
    .i_waddr(7'(i_req.addr - `OFF_LOOKUP_FIRST)),
    .i_wdata(i_req.wdata),
    .i_host_idx(7'(i_req.addr - `OFF_LOOKUP_FIRST)),
    .i_comp_idx(index_q[7] ? `LOOKUP_LAST_INDEX : index_q[6:0]),
    .o_host_data(lut_host),
    .o_comp_data(lut_comp)
  );

  // Entry is signed 7-bit when added, plain unsigned otherwise
  always_comb begin
    if (adder) begin
      auto_wiper = sat7($signed({2'b00, init_q}) + $signed({{3{lut_comp[6]}}, lut_comp[6:0]}));
    end else begin
      auto_wiper = sat7($signed({2'b00, lut_comp}));
    end
  end

  // Power-up recall takes one cycle; host access waits for it
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= ST_RECALL;
    end else begin
      case (state_q)
        ST_RECALL: state_q <= ST_RUN;
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_RECALL;
      endcase
    end
  end

  // Nonvolatile copies: kept over reset, only erase or writes change them
  always_ff @(posedge i_clock) begin
    if (i_nv_erase) begin
      nv_mode_q <= `RST_WIPER_MODE_CONTROL;
      init_q <= `RST_INITIAL_VALUE;
    end else begin
      if (w03 && !inhibit_q) begin
        nv_mode_q <= {6'h00, i_req.wdata[1:0]};
      end
      if (w00 && !inhibit_q) begin
        init_q <= i_req.wdata;
      end
    end
  end

  // Shadow mode control
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mode_q <= `RST_WIPER_MODE_CONTROL;
    end else if (state_q == ST_RECALL) begin
      mode_q <= nv_mode_q;
    end else if (w03) begin
      mode_q <= {6'h00, i_req.wdata[1:0]};
    end
  end

  // Volatile control bits
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      inhibit_q <= 1'b0;
      ovr_index_q <= 1'b0;
      ovr_manual_q <= 1'b0;
    end else begin
      if (w02) begin
        inhibit_q <= i_req.wdata[`BIT_NV_WRITE_INHIBIT];
      end
      if (w0a) begin
        // Reserved bit 0 is expected at 0 and is not stored
        ovr_index_q <= i_req.wdata[`BIT_INDEX_OVERRIDE];
        ovr_manual_q <= i_req.wdata[`BIT_MANUAL_WIPER];
      end
    end
  end

  // Lookup index
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      index_q <= `RST_ZERO;
    end else if (w08 && ovr_index_q) begin
      index_q <= i_req.wdata;
    end else if (run && upd && !ovr_index_q && i_conv.valid) begin
      index_q <= temp_to_index(i_conv.temp);
    end
  end

  // Wiper reload is one cycle after the index so it sees the new slot
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      load_q <= 1'b0;
    end else begin
      load_q <= run && upd && i_conv.valid;
    end
  end

  // Wiper value
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wiper_q <= 7'(`RST_ZERO);
    end else if (state_q == ST_RECALL) begin
      wiper_q <= init_q[6:0];
    end else if (w00) begin
      wiper_q <= i_req.wdata[6:0];
    end else if (upd && ovr_manual_q) begin
      if (w09) begin
        wiper_q <= i_req.wdata[6:0];
      end
    end else if (upd && load_q) begin
      wiper_q <= auto_wiper;
    end
  end

  // Converter results, written only while the converter is enabled
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      temp_q <= `RST_ZERO;
      volt_q <= `RST_ZERO;
    end else if (run && upd && i_conv.valid) begin
      // Recall cycle still shows the reset mode, so samples wait for run
      temp_q <= i_conv.temp;
      volt_q <= i_conv.volt;
    end
  end

  // Read data, one cycle after the request
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_q <= `RST_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= run && i_req.rd;
      if (run && i_req.rd) begin
        if (lut_hit) begin
          rdata_q <= lut_host;
        end else begin
          case (i_req.addr)
            `OFF_INITIAL_VALUE: rdata_q <= inhibit_q ? {1'b0, wiper_q} : init_q;
            `OFF_SHADOW_CONTROL: rdata_q <= {inhibit_q, 7'h00};
            `OFF_WIPER_MODE_CONTROL: rdata_q <= mode_q;
            `OFF_LOOKUP_INDEX: rdata_q <= index_q;
            `OFF_WIPER_VALUE: rdata_q <= {1'b0, wiper_q};
            `OFF_WIPER_OVERRIDE_CONTROL: rdata_q <= {5'h00, ovr_manual_q, ovr_index_q, 1'b0};
            `OFF_TEMPERATURE_RESULT: rdata_q <= temp_q;
            `OFF_SUPPLY_RESULT: rdata_q <= volt_q;
            default: rdata_q <= `RST_ZERO;
          endcase
        end
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_conv_enable = upd;
  assign o_wiper = wiper_q;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_recall;
    state_q == ST_RECALL;
  endsequence

  sequence s_conv_auto;
    run && upd && !ovr_index_q && i_conv.valid && !(w08);
  endsequence

  property p_recall_mode;
    s_recall |=> (mode_q == $past(nv_mode_q)) && (wiper_q == $past(init_q[6:0]));
  endproperty
  a_recall_mode: assert property (p_recall_mode) else $error("Power-up recall lost");

  property p_temp_frozen;
    !upd |=> $stable(temp_q) && $stable(volt_q);
  endproperty
  a_temp_frozen: assert property (p_temp_frozen) else $error("Result changed while disabled");

  property p_index_auto;
    s_conv_auto |=> index_q == temp_to_index($past(i_conv.temp));
  endproperty
  a_index_auto: assert property (p_index_auto) else $error("Index not recomputed");

  property p_index_frozen;
    (ovr_index_q && !w08 && !w0a) |=> $stable(index_q);
  endproperty
  a_index_frozen: assert property (p_index_frozen) else $error("Index moved under override");

  property p_index_refused;
    (w08 && !ovr_index_q && !i_conv.valid) |=> $stable(index_q);
  endproperty
  a_index_refused: assert property (p_index_refused) else $error("Index write not refused");

  property p_manual_write;
    (w09 && ovr_manual_q && upd) |=> wiper_q == $past(i_req.wdata[6:0]);
  endproperty
  a_manual_write: assert property (p_manual_write) else $error("Manual wiper write lost");

  property p_manual_hold;
    (upd && ovr_manual_q && !w09 && !w00 && !w0a && !w03) [*2] |=> $stable(wiper_q);
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("Wiper auto-loaded in manual");

  property p_inhibit_nv;
    (w00 && inhibit_q && !i_nv_erase) |=> $stable(init_q) && (wiper_q == $past(i_req.wdata[6:0]));
  endproperty
  a_inhibit_nv: assert property (p_inhibit_nv) else $error("Initial value written while inhibited");

  property p_nv_write;
    (w00 && !inhibit_q && !i_nv_erase) |=> init_q == $past(i_req.wdata);
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("Initial value not stored");

  property p_auto_load;
    (s_conv_auto and (!ovr_manual_q && !w03 && !w0a)) ##1 (!w00 && !w03 && !w0a)
      |=> wiper_q == $past(auto_wiper);
  endproperty
  a_auto_load: assert property (p_auto_load) else $error("Wiper not refreshed from lookup");

  property p_wiper_read;
    (run && i_req.rd && hit(i_req.addr, `OFF_WIPER_VALUE)) |=> o_rvalid && !o_rdata[7];
  endproperty
  a_wiper_read: assert property (p_wiper_read) else $error("Wiper read bad");

  property p_inhibit_reset;
    disable iff (1'b0) !i_rst_n |=> !inhibit_q;
  endproperty
  a_inhibit_reset: assert property (p_inhibit_reset) else $error("Inhibit not cleared");
endmodule

// [rtl/wiper_ctrl_cfg.svh]
// Purpose: Offsets, field positions and reset values of the wiper register bank
// Assumes: 8-bit register port, one clock
// Notes: Definitions only
`ifndef WIPER_CTRL_CFG_SVH
`define WIPER_CTRL_CFG_SVH

`define OFF_INITIAL_VALUE 8'h00
`define OFF_SHADOW_CONTROL 8'h02
`define OFF_WIPER_MODE_CONTROL 8'h03
`define OFF_LOOKUP_INDEX 8'h08
`define OFF_WIPER_VALUE 8'h09
`define OFF_WIPER_OVERRIDE_CONTROL 8'h0A
`define OFF_TEMPERATURE_RESULT 8'h0C
`define OFF_SUPPLY_RESULT 8'h0E
`define OFF_LOOKUP_FIRST 8'h80
`define OFF_LOOKUP_LAST 8'hC7

`define BIT_UPDATE_SELECT 0
`define BIT_ADDER_SELECT 1
`define BIT_INDEX_OVERRIDE 1
`define BIT_MANUAL_WIPER 2
`define BIT_NV_WRITE_INHIBIT 7

`define RST_WIPER_MODE_CONTROL 8'h03
`define RST_INITIAL_VALUE 8'h00
`define RST_LOOKUP_ENTRY 8'h00
`define RST_ZERO 8'h00

`define LOOKUP_DEPTH 72
`define LOOKUP_LAST_INDEX 7'h47
`define TEMP_INDEX_BIAS 10'h029
`define WIPER_MAX 7'h7F

`endif

// [rtl/wiper_ctrl_pkg.sv]
// Purpose: Types shared by the wiper register bank
// Assumes: Constants come from wiper_ctrl_cfg.svh
// Notes: Types only
package wiper_ctrl_pkg;

  // One register access from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // One finished conversion frame from the converter
  typedef struct packed {
    logic valid;
    logic [7:0] temp;
    logic [7:0] volt;
  } conv_sample_t;

  typedef enum logic [1:0] {
    ST_RECALL = 2'b01,
    ST_RUN = 2'b10
  } boot_state_t;

endpackage

// [verification/reg_host.sv]
// Purpose: Host model that makes single-byte register accesses
// Assumes: A request is taken on a rising edge and read data stands one cycle later
// Notes: Released address and data show the inverse of the last value, so stale bytes are never reused
`timescale 1ns/100ps
module reg_host (
  // Clock
  input wire logic i_clock,
  // Register port
  output wiper_ctrl_pkg::reg_req_t o_req,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  import wiper_ctrl_pkg::*;
  initial o_req = '0;
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clock);
    #1;
    if (a == 8'h0A) d[0] = 1'b0;
    o_req = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge i_clock);
    #1;
    q = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// [verification/temp_compensated_wiper_control_test.sv]
// Purpose: Self-checking bench for the wiper register bank
// Assumes: Lookup entries live at 80h and up, index is the slot number
// Notes: Frames are pulsed by hand; no free-running converter
`timescale 1ns/100ps
module temp_compensated_wiper_control_test;
  import wiper_ctrl_pkg::*;
  logic clock;
  logic rst_n = 1'b0;
  logic nv_erase = 1'b1;
  reg_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  conv_sample_t conv = '0;
  logic conv_enable;
  logic [6:0] wiper;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  temp_compensated_wiper_control temp_compensated_wiper_control_i (
    .i_clock(clock), .i_rst_n(rst_n), .i_nv_erase(nv_erase), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_conv(conv), .o_conv_enable(conv_enable), .o_wiper(wiper));
  reg_host reg_host_i (.i_clock(clock), .o_req(req), .i_rdata(rdata), .i_rvalid(rvalid));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Generous ceiling, the run needs under 150 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("wrong value timeout expected done seen hang");
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    reg_host_i.access(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    reg_host_i.access(1'b0, a, 8'h00, q);
    check($sformatf("reg %h", a), e, q);
  endtask
  task automatic wiper_chk(input logic [6:0] e);
    check("wiper", {1'b0, e}, {1'b0, wiper});
  endtask
  task automatic frame(input logic [7:0] t);
    @(posedge clock);
    #1;
    conv = '{valid: 1'b1, temp: t, volt: ~t};
    @(posedge clock);
    #1;
    conv.valid = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic do_reset(input int n);
    @(posedge clock);
    #1;
    rst_n = 1'b0;
    repeat (n) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clock);
  endtask

  task automatic t_reset();
    rd_chk(8'h03, 8'h03);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h00);
    rd_chk(8'h0A, 8'h00);
    rd_chk(8'h02, 8'h00);
    check("conv enable", 8'h01, {7'h00, conv_enable});
    wr(8'h08, 8'h05);
    rd_chk(8'h08, 8'h00);
    wr(8'h09, 8'h22);
    rd_chk(8'h09, 8'h00);
    rd_chk(8'h05, 8'h00);
    $display("test reset and refused writes done");
  endtask

  task automatic t_lookup();
    wr(8'h00, 8'h20);
    wr(8'hA1, 8'h05);
    frame(8'h19);
    rd_chk(8'h08, 8'h21);
    rd_chk(8'h0C, 8'h19);
    wiper_chk(7'h25);
    frame(8'hF6);
    rd_chk(8'h08, 8'h0F);
    rd_chk(8'h0C, 8'hF6);
    wiper_chk(7'h20);
    wr(8'h03, 8'h01);
    frame(8'h19);
    wiper_chk(7'h05);
    wr(8'h03, 8'h03);
    wr(8'hA1, 8'h7E);
    rd_chk(8'hA1, 8'h7E);
    frame(8'h19);
    wiper_chk(7'h1E);
    rd_chk(8'h09, 8'h1E);
    $display("test lookup modes done");
  endtask

  task automatic t_override();
    wr(8'h0A, 8'h02);
    wr(8'h08, 8'h10);
    rd_chk(8'h08, 8'h10);
    frame(8'h19);
    rd_chk(8'h08, 8'h10);
    wiper_chk(7'h20);
    wr(8'h0A, 8'hFF);
    rd_chk(8'h0A, 8'h06);
    wr(8'h09, 8'h55);
    rd_chk(8'h09, 8'h55);
    frame(8'h19);
    wiper_chk(7'h55);
    wr(8'h0A, 8'h00);
    $display("test overrides done");
  endtask

  task automatic t_hold();
    wr(8'h03, 8'h00);
    check("conv enable", 8'h00, {7'h00, conv_enable});
    frame(8'h32);
    rd_chk(8'h0C, 8'h19);
    rd_chk(8'h0E, 8'hE6);
    wr(8'h00, 8'h30);
    rd_chk(8'h09, 8'h30);
    wiper_chk(7'h30);
    wr(8'h03, 8'h02);
    frame(8'h40);
    wiper_chk(7'h30);
    rd_chk(8'h0C, 8'h19);
    $display("test update off done");
  endtask

  task automatic t_shadow();
    wr(8'h02, 8'h80);
    wr(8'h00, 8'h40);
    rd_chk(8'h00, 8'h40);
    wiper_chk(7'h40);
    wr(8'h03, 8'h01);
    rd_chk(8'h03, 8'h01);
    do_reset(2);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h02);
    wiper_chk(7'h30);
    rd_chk(8'h00, 8'h30);
    check("conv enable", 8'h00, {7'h00, conv_enable});
    $display("test shadow and recall done");
  endtask

  initial begin
    // Erase stands in for factory programming; nonvolatile copies have no reset
    repeat (6) @(posedge clock);
    #1;
    nv_erase = 1'b0;
    rst_n = 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_lookup();
    t_override();
    t_hold();
    t_shadow();
    end_of_test();
  end
endmodule
